// file: common/sfm_pkg.sv
/*
 * sfm_pkg: register map, field layout, reset values and mode codes of
 * the synthesizer frequency modulation control block.
 * assumes: included by every sfm design file through sfm_pkg::*.
 */
package sfm_pkg;

    ////////////////////////////////////////////////////////////////////
    // register byte offsets on the axi4-lite slave
    localparam logic [7:0] SFM_ADDR_SETUP  = 8'h00; // mod_setup_reg
    localparam logic [7:0] SFM_ADDR_OFFSET = 8'h04; // mod_offset_reg
    localparam logic [7:0] SFM_ADDR_STATUS = 8'h08; // live state
    localparam logic [7:0] SFM_ADDR_DEV    = 8'h0c; // applied deviation

    ////////////////////////////////////////////////////////////////////
    // field positions in mod_setup_reg
    localparam int SFM_SEL_LSB  = 0;  // mod_setup_sel, 2 bits
    localparam int SFM_SEL_W    = 2;
    localparam int SFM_STEP_LSB = 4;  // mod_step_exp
    localparam int SFM_STEP_W   = 4;
    localparam int SFM_GPO_BIT  = 8;  // keying pin level as output
    localparam int SFM_OFF_W    = 16; // mod_offset_reg width
    localparam int SFM_DEV_W    = 32; // deviation word width

    ////////////////////////////////////////////////////////////////////
    // reset values and response codes
    localparam logic [1:0]  SFM_RST_SEL  = 2'h0;
    localparam logic [3:0]  SFM_RST_STEP = 4'h0;
    localparam logic [15:0] SFM_RST_OFF  = 16'h0000;
    localparam logic [1:0]  SFM_RESP_OK  = 2'h0;
    localparam logic [1:0]  SFM_RESP_ERR = 2'h2;

    ////////////////////////////////////////////////////////////////////
    // modulation setup codes
    typedef enum logic [1:0] {
        SFM_MODE_OFF  = 2'b00,
        SFM_MODE_CONT = 2'b01,
        SFM_MODE_RSVD = 2'b10,
        SFM_MODE_FSK  = 2'b11
    } sfm_mode_type;

endpackage : sfm_pkg

// file: rtl/sfm_sync2.sv
/*
 * sfm_sync2: two flip-flop synchroniser for one pin level.
 * assumes: i_async may change at any time relative to i_clk_sys.
 */
`timescale 1ns/1ps
module sfm_sync2
    import sfm_pkg::*;
(
    input  wire logic i_clk_sys, // system clock
    input  wire logic i_rst_n,   // async reset, active low
    input  wire logic i_async,   // raw pin level
    output logic      o_sync     // level after two flops
);

    typedef struct packed {
        logic meta;
        logic sync;
    } sfm_sync_type;

    sfm_sync_type st_ff;
    sfm_sync_type nxt_st;

    always_comb
    begin
        nxt_st.meta = i_async;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign o_sync = st_ff.sync;

endmodule : sfm_sync2

// file: rtl/sfm_top.sv
/*
 * sfm_top: frequency modulation control of the fractional-N synthesizer,
 * with its setup and offset registers on an axi4-lite slave.
 * assumes: one 40 MHz clock; the keying pin comes from outside and is
 * synchronised here; o_fm_word is added to the fractional divider word.
 */
// Function
// - setup pattern 11 selects two-level keying
// - keying mode turns keying pin into input
// - deviation uses step field and offset word
// - deviation = 2^step * Fpd * offset / 2^16
// - offset word is two's complement signed
// - setup pattern 01 selects continuous modulation
// - offset write retunes at once, no relock
// - dedicated setup and offset registers exist
`timescale 1ns/1ps
module sfm_top
    import sfm_pkg::*;
(
    input  wire logic        i_clk_sys,         // 40 MHz system clock
    input  wire logic        i_rst_n,           // async reset, active low
    input  wire logic [7:0]  s_axi_awaddr,      // write address
    input  wire logic        s_axi_awvalid,     // write address valid
    output logic             s_axi_awready,     // write address ready
    input  wire logic [31:0] s_axi_wdata,       // write data
    input  wire logic [3:0]  s_axi_wstrb,       // write byte strobes
    input  wire logic        s_axi_wvalid,      // write data valid
    output logic             s_axi_wready,      // write data ready
    output logic [1:0]       s_axi_bresp,       // write response
    output logic             s_axi_bvalid,      // write response valid
    input  wire logic        s_axi_bready,      // write response ready
    input  wire logic [7:0]  s_axi_araddr,      // read address
    input  wire logic        s_axi_arvalid,     // read address valid
    output logic             s_axi_arready,     // read address ready
    output logic [31:0]      s_axi_rdata,       // read data
    output logic [1:0]       s_axi_rresp,       // read response
    output logic             s_axi_rvalid,      // read data valid
    input  wire logic        s_axi_rready,      // read data ready
    input  wire logic        i_keying_pin_i,    // keying pin level in
    output logic             o_keying_pin_o,    // keying pin drive level
    output logic             o_keying_pin_oe_n, // low while driving pin
    output logic [31:0]      o_fm_word,         // deviation, Fpd/2^16 units
    output logic             o_fm_active        // modulation mode on
);

    ////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic         aw_got;
        logic         w_got;
        logic [7:0]   aw_addr;
        logic [31:0]  w_data;
        logic [3:0]   w_strb;
        logic         aw_rdy;
        logic         w_rdy;
        logic         b_vld;
        logic [1:0]   b_resp;
        logic         ar_rdy;
        logic         r_vld;
        logic [1:0]   r_resp;
        logic [31:0]  r_data;
        sfm_mode_type mode_sel;
        logic [3:0]   step_exp;
        logic         gpo_lvl;
        logic [15:0]  offset;
        logic [31:0]  fm_word;
        logic         fm_active;
        logic         pin_o;
        logic         pin_oe_n;
    } sfm_state_type;

    sfm_state_type st_ff;
    sfm_state_type nxt_st;
    logic          key_lvl;

    sfm_sync2 u_key_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (i_keying_pin_i),
        .o_sync    (key_lvl)
    );

    // offset sign-extended then scaled by 2^step
    function automatic logic [31:0] sfm_dev(input logic [15:0] off,
                                            input logic [3:0]  stp);
        logic [31:0] ext;
        ext = {{16{off[15]}}, off};
        return ext << stp;
    endfunction : sfm_dev

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        logic [31:0] wr_mask;
        logic [31:0] cur;
        logic [31:0] dev;
        wr_mask = '0;
        cur     = '0;
        dev     = '0;
        nxt_st  = st_ff;

        // write address and data, taken in either order
        if (s_axi_awvalid && st_ff.aw_rdy)
        begin
            nxt_st.aw_got  = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.w_rdy)
        begin
            nxt_st.w_got  = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        if (st_ff.b_vld && s_axi_bready)
            nxt_st.b_vld = 1'b0;

        // perform write once both halves are held
        if (st_ff.aw_got && st_ff.w_got && !st_ff.b_vld)
        begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.b_vld  = 1'b1;
            nxt_st.b_resp = SFM_RESP_OK;
            for (int i = 0; i < 4; i++)
                wr_mask[i*8 +: 8] = {8{st_ff.w_strb[i]}};
            case (st_ff.aw_addr[7:2])
                SFM_ADDR_SETUP[7:2]:
                begin
                    cur = 32'(st_ff.mode_sel) << SFM_SEL_LSB;
                    cur = cur | (32'(st_ff.step_exp) << SFM_STEP_LSB);
                    cur[SFM_GPO_BIT] = st_ff.gpo_lvl;
                    cur = (cur & ~wr_mask) | (st_ff.w_data & wr_mask);
                    nxt_st.mode_sel = sfm_mode_type'(
                        cur[SFM_SEL_LSB +: SFM_SEL_W]);
                    nxt_st.step_exp = cur[SFM_STEP_LSB +: SFM_STEP_W];
                    nxt_st.gpo_lvl  = cur[SFM_GPO_BIT];
                end
                SFM_ADDR_OFFSET[7:2]:
                begin
                    cur = {16'h0000, st_ff.offset};
                    cur = (cur & ~wr_mask) | (st_ff.w_data & wr_mask);
                    nxt_st.offset = cur[15:0];
                end
                SFM_ADDR_STATUS[7:2], SFM_ADDR_DEV[7:2]:
                    nxt_st.b_resp = SFM_RESP_OK; // read-only, ignored
                default:
                    nxt_st.b_resp = SFM_RESP_ERR;
            endcase
        end
        nxt_st.aw_rdy = !nxt_st.aw_got;
        nxt_st.w_rdy  = !nxt_st.w_got;

        // read channel, one outstanding read
        if (st_ff.r_vld && s_axi_rready)
            nxt_st.r_vld = 1'b0;
        if (s_axi_arvalid && st_ff.ar_rdy)
        begin
            nxt_st.r_vld  = 1'b1;
            nxt_st.r_resp = SFM_RESP_OK;
            nxt_st.r_data = '0;
            case (s_axi_araddr[7:2])
                SFM_ADDR_SETUP[7:2]:
                begin
                    nxt_st.r_data[SFM_SEL_LSB +: SFM_SEL_W]   =
                        st_ff.mode_sel;
                    nxt_st.r_data[SFM_STEP_LSB +: SFM_STEP_W] =
                        st_ff.step_exp;
                    nxt_st.r_data[SFM_GPO_BIT] = st_ff.gpo_lvl;
                end
                SFM_ADDR_OFFSET[7:2]:
                    nxt_st.r_data[15:0] = st_ff.offset;
                SFM_ADDR_STATUS[7:2]:
                begin
                    nxt_st.r_data[1:0] = st_ff.mode_sel;
                    nxt_st.r_data[2]   = key_lvl;
                    nxt_st.r_data[3]   = st_ff.fm_active;
                    nxt_st.r_data[4]   = !st_ff.pin_oe_n;
                end
                SFM_ADDR_DEV[7:2]:
                    nxt_st.r_data = st_ff.fm_word;
                default:
                    nxt_st.r_resp = SFM_RESP_ERR;
            endcase
        end
        nxt_st.ar_rdy = !nxt_st.r_vld;

        // modulation path, follows the freshly written fields
        dev = sfm_dev(nxt_st.offset, nxt_st.step_exp);
        case (nxt_st.mode_sel)
            SFM_MODE_FSK:
            begin
                nxt_st.pin_oe_n  = 1'b1;
                nxt_st.pin_o     = 1'b0;
                nxt_st.fm_active = 1'b1;
                nxt_st.fm_word   = key_lvl ? dev : '0;
            end
            SFM_MODE_CONT:
            begin
                nxt_st.pin_oe_n  = 1'b0;
                nxt_st.pin_o     = nxt_st.gpo_lvl;
                nxt_st.fm_active = 1'b1;
                nxt_st.fm_word   = dev;
            end
            default:
            begin
                nxt_st.pin_oe_n  = 1'b0;
                nxt_st.pin_o     = nxt_st.gpo_lvl;
                nxt_st.fm_active = 1'b0;
                nxt_st.fm_word   = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_ff          <= '0;
            st_ff.aw_rdy   <= 1'b1;
            st_ff.w_rdy    <= 1'b1;
            st_ff.ar_rdy   <= 1'b1;
            st_ff.mode_sel <= SFM_MODE_OFF;
            st_ff.step_exp <= SFM_RST_STEP;
            st_ff.offset   <= SFM_RST_OFF;
        end
        else
            st_ff <= nxt_st;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign s_axi_awready     = st_ff.aw_rdy;
    assign s_axi_wready      = st_ff.w_rdy;
    assign s_axi_bvalid      = st_ff.b_vld;
    assign s_axi_bresp       = st_ff.b_resp;
    assign s_axi_arready     = st_ff.ar_rdy;
    assign s_axi_rvalid      = st_ff.r_vld;
    assign s_axi_rresp       = st_ff.r_resp;
    assign s_axi_rdata       = st_ff.r_data;
    assign o_keying_pin_o    = st_ff.pin_o;
    assign o_keying_pin_oe_n = st_ff.pin_oe_n;
    assign o_fm_word         = st_ff.fm_word;
    assign o_fm_active       = st_ff.fm_active;

endmodule : sfm_top

// file: testbench/sfm_top_asserts.sv
/* sfm_top_asserts: port checks for sfm_top.
   assumes: bound into sfm_top; one clock, async low reset. */
`timescale 1ns/1ps
module sfm_top_asserts
    import sfm_pkg::*;
(
    input wire logic        i_clk_sys,         // clock
    input wire logic        i_rst_n,           // reset, low
    input wire logic        s_axi_awvalid,     // aw valid
    input wire logic        s_axi_awready,     // aw ready
    input wire logic        s_axi_wvalid,      // w valid
    input wire logic        s_axi_wready,      // w ready
    input wire logic [1:0]  s_axi_bresp,       // b code
    input wire logic        s_axi_bvalid,      // b valid
    input wire logic        s_axi_bready,      // b ready
    input wire logic        s_axi_arvalid,     // ar valid
    input wire logic        s_axi_arready,     // ar ready
    input wire logic        s_axi_rvalid,      // r valid
    input wire logic        i_keying_pin_i,    // key pin
    input wire logic        o_keying_pin_oe_n, // pin enable
    input wire logic [31:0] o_fm_word,         // deviation
    input wire logic        o_fm_active        // mode on
);
    default clocking dc @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    chk_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write unanswered");
    chk_b_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer not held");
    chk_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read unanswered");
    chk_ar_block: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
    chk_key_active: assert property (
        o_keying_pin_oe_n |-> o_fm_active) else $error("pin freed when off");
    chk_fm_idle: assert property (
        !o_fm_active |-> o_fm_word == 32'h0) else $error("word while off");
    chk_key_low: assert property (
        (o_keying_pin_oe_n && !i_keying_pin_i) [*4] |-> o_fm_word == 32'h0)
        else $error("key low not nominal");
    chk_key_rise: assert property (
        $rose(o_fm_word != 32'h0) && o_keying_pin_oe_n
        |-> $past(i_keying_pin_i, 3)) else $error("shift without key");
endmodule : sfm_top_asserts

bind sfm_top sfm_top_asserts u_chk (.i_clk_sys, .i_rst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .i_keying_pin_i, .o_keying_pin_oe_n, .o_fm_word,
    .o_fm_active);

// file: testbench/sfm_key_src.sv
/* sfm_key_src: data source on the keying pin, with pin resolution.
   assumes: the device lets go of the pin by raising its oe_n. */
`timescale 1ns/1ps
module sfm_key_src
(
    input  wire logic i_level,    // level the source sends
    input  wire logic i_dev_o,    // device drive level
    input  wire logic i_dev_oe_n, // low while device drives
    output logic      o_pin       // level on the wire
);
    always_comb
    begin
        if (!i_dev_oe_n)
            o_pin = i_dev_o;
        else
            o_pin = i_level;
    end
endmodule : sfm_key_src

// file: testbench/sfm_top_tb.sv
/* sfm_top_tb: self-checking bench for sfm_top.
   assumes: sfm_key_src drives the keying pin, 40 MHz clock. */
`timescale 1ns/1ps
module sfm_top_tb
    import sfm_pkg::*;
;
    logic        i_clk_sys = 1'b0, i_rst_n = 1'b0, key_lvl = 1'b0, kb;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, o_fm_word, rdv;
    logic [3:0]  s_axi_wstrb = 4'hf, st;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, md;
    logic        i_keying_pin_i, o_keying_pin_o, o_keying_pin_oe_n;
    logic        o_fm_active;
    logic [15:0] off;
    int          err_total = 0, check_count = 0, cycles = 0, seed = 97525;
    wire logic [31:0] pins = {29'h0, o_keying_pin_o, o_keying_pin_oe_n,
                              o_fm_active};

    always #12.5 i_clk_sys = ~i_clk_sys;

    sfm_top dut (.i_clk_sys, .i_rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_keying_pin_i,
        .o_keying_pin_o, .o_keying_pin_oe_n, .o_fm_word, .o_fm_active);
    sfm_key_src u_src (.i_level(key_lvl), .i_dev_o(o_keying_pin_o),
        .i_dev_oe_n(o_keying_pin_oe_n), .o_pin(i_keying_pin_i));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ew(input logic [1:0] m,
        input logic [3:0] s, input logic [15:0] o, input logic k);
        logic [31:0] w;
        w = {{16{o[15]}}, o} << s;
        return (m == 2'b01 || (m == 2'b11 && k)) ? w : 32'h0;
    endfunction : ew

    task automatic check(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= (n == 0);
        do
        begin
            @(posedge i_clk_sys);
            n--;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n == 0) s_axi_bready <= 1'b1;
        end
        while (!(s_axi_bvalid && s_axi_bready));
        rsp = s_axi_bresp;
    endtask : wr

    task automatic rd(input logic [7:0] a, input int n);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= (n == 0);
        do
        begin
            @(posedge i_clk_sys);
            n--;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n == 0) s_axi_rready <= 1'b1;
        end
        while (!(s_axi_rvalid && s_axi_rready));
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : rd

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            conclude();
        end
    end

    initial
    begin
        repeat (10) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        rd(SFM_ADDR_SETUP, 2);
        check("setup reset", rdv, 32'h0);
        rd(8'h10, 1);
        check("bad read", {rsp, rdv[29:0]}, {SFM_RESP_ERR, 30'h0});
        wr(8'h14, 32'h1, 2);
        check("bad write", {30'h0, rsp}, {30'h0, SFM_RESP_ERR});
        wr(SFM_ADDR_SETUP, 32'h0000_0100, 1);
        check("gpo pins", pins, 32'h4);
        repeat (2) @(posedge i_clk_sys);
        rd(SFM_ADDR_STATUS, 0);
        check("gpo status", rdv, 32'h14);
        s_axi_wstrb <= 4'he;
        wr(SFM_ADDR_SETUP, 32'h0000_0033, 0);
        s_axi_wstrb <= 4'hf;
        rd(SFM_ADDR_SETUP, 1);
        check("strobe merge", rdv, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 24; i++)
        begin
            md = (i < 4) ? 2'(3 - i) : 2'b01;
            st = (i == 5) ? 4'hf : 4'($random(seed));
            off = (i == 6) ? 16'h8000 : 16'($random(seed));
            wr(SFM_ADDR_SETUP, {24'h0, st, 2'h0, md}, i % 3);
            wr(SFM_ADDR_OFFSET, {16'h0, off}, 0);
            check("fm word", o_fm_word, ew(md, st, off, 1'b0));
            check("pins", pins, {29'h0, 1'b0, &md, md[0]});
            rd(SFM_ADDR_STATUS, i % 2);
            check("status", {30'h0, rdv[1:0]}, {30'h0, md});
        end
        $display("test modes done");
        wr(SFM_ADDR_SETUP, 32'h0000_0033, 1);
        wr(SFM_ADDR_OFFSET, 32'h0000_fff0, 0);
        for (int k = 0; k < 10; k++)
        begin
            kb = (k < 2) ? k[0] : 1'($random(seed));
            key_lvl <= kb;
            repeat (4) @(posedge i_clk_sys);
            check("keyed", o_fm_word, ew(2'b11, 4'h3, 16'hfff0, kb));
            rd(SFM_ADDR_DEV, k % 2);
            check("dev reg", rdv, ew(2'b11, 4'h3, 16'hfff0, kb));
            rd(SFM_ADDR_STATUS, 0);
            check("key status", rdv, {27'h0, 2'b01, kb, 2'b11});
        end
        $display("test keying done");
        conclude();
    end
endmodule : sfm_top_tb
